/* File: ssab_front_end.sv */
// serial slave front end: detection, lock gating, address, test timer and apb registers
//
// Design decisions made here: the placing of the registers and register access over APB.
`include "ssab_regs.svh"
module ssab_front_end #(
  parameter int TEST_CYCLES = `SSAB_TEST_CYCLES,
  parameter int LOCK_FRAMES = `SSAB_LOCK_FRAMES
) (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic RX_I,
  output logic TX_O,
  output logic TX_EN_O,
  input wire logic [3:0] ADDR_TENS_I,
  input wire logic [3:0] ADDR_UNITS_I,
  input wire logic LOCK_CLOSED_I,
  input wire logic TEST_BUTTON_I,
  output logic TEST_ACTIVE_O,
  output logic TRAFFIC_LED_O,
  output logic CMD_ALLOWED_O
);
  localparam int CLK_HZ = `SSAB_CLK_HZ;
  logic [31:0] ctrl;
  ssab_pkg::ssab_link_type manual_link;
  ssab_pkg::ssab_link_type cand_link;
  ssab_pkg::ssab_link_type link;
  logic locked;
  logic [3:0] cand_idx;
  logic [7:0] good_cnt;
  logic [15:0] bit_cycles;
  ssab_pkg::ssab_rxchar_type rx_char;
  logic rx_done;
  logic rx_busy;
  logic [6:0] slave_addr;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_in_ready;
  logic [31:0] test_cnt;
  logic test_btn_d;
  logic [7:0] tx_byte;
  logic tx_load;
  logic tx_busy;
  logic [3:0] tx_bits;
  logic [15:0] tx_cnt;
  logic [11:0] tx_sh;
  logic [7:0] last_func;
  logic [1:0] byte_pos;
  logic apb_acc;

  assign manual_link.rate = ssab_pkg::ssab_rate_type'(ctrl[`SSAB_CTRL_RATE_LSB +: 2]);
  assign manual_link.par = ssab_pkg::ssab_par_type'(ctrl[`SSAB_CTRL_PAR_LSB +: 2]);
  assign manual_link.stop2 = ctrl[`SSAB_CTRL_STOP2_BIT];
  // candidate list walks all rates for even, then odd, then none with two stops
  assign cand_link.rate = ssab_pkg::ssab_rate_type'(cand_idx[1:0]);
  assign cand_link.par = cand_idx[3] ? ssab_pkg::SSAB_PAR_NONE :
                         cand_idx[2] ? ssab_pkg::SSAB_PAR_ODD : ssab_pkg::SSAB_PAR_EVEN;
  assign cand_link.stop2 = cand_idx[3];
  assign link = (ctrl[`SSAB_CTRL_AUTO_BIT] && !locked) ? cand_link :
                ctrl[`SSAB_CTRL_AUTO_BIT] ? cand_link : manual_link;

  always_comb begin
    unique case (link.rate)
      ssab_pkg::SSAB_B4800: bit_cycles = 16'(CLK_HZ / 4800);
      ssab_pkg::SSAB_B9600: bit_cycles = 16'(CLK_HZ / 9600);
      ssab_pkg::SSAB_B19200: bit_cycles = 16'(CLK_HZ / 19200);
      ssab_pkg::SSAB_B38400: bit_cycles = 16'(CLK_HZ / 38400);
    endcase
  end

  ssab_uart_rx u_rx (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .rx_i(RX_I),
    .bit_cycles_i(bit_cycles),
    .link_i(link),
    .char_o(rx_char),
    .done_o(rx_done),
    .busy_o(rx_busy)
  );

  // detection: lock after enough clean frames, step candidate on a bad one
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      locked <= 1'b0;
      cand_idx <= 4'h0;
      good_cnt <= 8'h00;
    end else if (ctrl[`SSAB_CTRL_AUTO_BIT] && !locked && rx_done) begin
      if (rx_char.ok) begin
        good_cnt <= good_cnt + 8'h01;
        if (good_cnt == 8'(LOCK_FRAMES - 1)) begin
          locked <= 1'b1;
        end
      end else begin
        good_cnt <= 8'h00;
        cand_idx <= (cand_idx == 4'hB) ? 4'h0 : cand_idx + 4'h1;
      end
    end
  end

  // limitation: a no-parity master can pass a parity candidate when its data parity agrees

  // tens widened first, a four-bit product would wrap above 15
  assign slave_addr = 7'(ADDR_TENS_I) * 7'd10 + 7'(ADDR_UNITS_I);

  ssab_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
    .clk_i(CLK_I),
    .rstn_i(RSTN_I),
    .in_data_i(rx_char.data),
    .in_valid_i(rx_done && rx_char.ok),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  // byte 0 is the address, byte 1 the function; a command check uses the latter
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      byte_pos <= 2'h0;
      last_func <= 8'h00;
    end else if (fifo_pop) begin
      if (byte_pos != 2'h2) begin
        byte_pos <= byte_pos + 2'h1;
      end
      if (byte_pos == 2'h1) begin
        last_func <= fifo_data;
      end
    end else if (!rx_busy && !fifo_valid) begin
      byte_pos <= 2'h0;
    end
  end

  // upstream server lock has no input here, so only the local selector gates
  assign CMD_ALLOWED_O = !LOCK_CLOSED_I ||
                         last_func == `SSAB_FUNC_SET_TIME ||
                         last_func == `SSAB_FUNC_GET_TIME;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      test_btn_d <= 1'b0;
      test_cnt <= 32'h0000_0000;
    end else begin
      test_btn_d <= TEST_BUTTON_I;
      if (TEST_BUTTON_I && !test_btn_d && test_cnt == 32'h0000_0000) begin
        test_cnt <= 32'(TEST_CYCLES);
      end else if (test_cnt != 32'h0000_0000) begin
        test_cnt <= test_cnt - 32'h0000_0001;
      end
    end
  end
  // test is a flag only; receive and transmit paths never look at it
  assign TEST_ACTIVE_O = (test_cnt != 32'h0000_0000);

  assign TRAFFIC_LED_O = (slave_addr == 7'h00) ? 1'b1 : (rx_busy || tx_busy);

  // transmitter: frame built as start, data, parity or second stop, stop
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      tx_busy <= 1'b0;
      tx_bits <= 4'h0;
      tx_cnt <= 16'h0000;
      tx_sh <= 12'hFFF;
    end else if (!tx_busy) begin
      if (tx_load && (locked || !ctrl[`SSAB_CTRL_AUTO_BIT])) begin
        tx_busy <= 1'b1;
        tx_cnt <= bit_cycles;
        tx_bits <= (link.par == ssab_pkg::SSAB_PAR_NONE && !link.stop2) ? 4'hA : 4'hB;
        // start bit goes out at once and the last stop bit stays inside tx_en
        tx_sh <= {2'b11,
                  (link.par == ssab_pkg::SSAB_PAR_NONE) ? 1'b1 :
                  (^tx_byte) ^ (link.par == ssab_pkg::SSAB_PAR_ODD),
                  tx_byte, 1'b0};
      end
    end else if (tx_cnt != 16'h0000) begin
      tx_cnt <= tx_cnt - 16'h0001;
    end else begin
      tx_sh <= {1'b1, tx_sh[11:1]};
      tx_cnt <= bit_cycles;
      tx_bits <= tx_bits - 4'h1;
      if (tx_bits == 4'h1) begin
        tx_busy <= 1'b0;
      end
    end
  end
  assign TX_O = tx_sh[0];
  assign TX_EN_O = tx_busy;

  // apb slave, zero wait states
  assign apb_acc = PSEL_I && PENABLE_I;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = apb_acc && !(PADDR_I == `SSAB_CTRL_OFS || PADDR_I == `SSAB_STAT_OFS ||
                     PADDR_I == `SSAB_RXDATA_OFS || PADDR_I == `SSAB_TXDATA_OFS);
  assign fifo_pop = apb_acc && !PWRITE_I && PADDR_I == `SSAB_RXDATA_OFS && fifo_valid;
  assign tx_load = apb_acc && PWRITE_I && PADDR_I == `SSAB_TXDATA_OFS;
  assign tx_byte = PWDATA_I[7:0];

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl <= `SSAB_CTRL_RST;
    end else if (apb_acc && PWRITE_I && PADDR_I == `SSAB_CTRL_OFS) begin
      // address and lock have no writable bits at all
      ctrl <= {26'h0, PWDATA_I[5:0]};
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      unique case (PADDR_I)
        `SSAB_CTRL_OFS: PRDATA_O <= ctrl;
        `SSAB_STAT_OFS: PRDATA_O <= {8'h00, 1'b0, slave_addr, 1'b0, cand_idx, fifo_in_ready,
                                      tx_busy, TEST_ACTIVE_O, LOCK_CLOSED_I, locked, 4'h0,
                                      fifo_valid, CMD_ALLOWED_O};
        `SSAB_RXDATA_OFS: PRDATA_O <= {24'h0, fifo_data};
        default: PRDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  AST_LOCK_STAYS: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    locked |=> locked) else $error("detected link lost before reset");
  AST_NO_TX_UNLOCKED: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (ctrl[0] && !locked) |-> !TX_EN_O) else $error("reply before detection lock");
  AST_LOCK_GATE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (LOCK_CLOSED_I && last_func == 8'h03) |-> !CMD_ALLOWED_O) else $error("closed lock passed cmd");
  AST_OPEN_PASS: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !LOCK_CLOSED_I |-> CMD_ALLOWED_O) else $error("open lock blocked cmd");
  AST_TEST_START: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (TEST_BUTTON_I && !test_btn_d && !TEST_ACTIVE_O) |=> TEST_ACTIVE_O) else $error("test not started");
  AST_LED_ZERO: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (ADDR_TENS_I == 4'h0 && ADDR_UNITS_I == 4'h0) |-> TRAFFIC_LED_O) else $error("led not steady");
  AST_LED_IDLE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (slave_addr != 7'h00 && !rx_busy && !tx_busy) |-> !TRAFFIC_LED_O) else $error("led lit idle");
  AST_ADDR_RANGE: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    (ADDR_TENS_I < 4'hA && ADDR_UNITS_I < 4'hA) |-> slave_addr <= `SSAB_MAX_ADDR) else $error("address range");
endmodule : ssab_front_end

/* File: ssab_regs.svh */
// register offsets, field positions, reset values and timing counts of the serial front end
// Summary of operation
// - lock open (default): remote control commands are accepted and forwarded.
// - lock closed: only set-time and get-time commands pass, others rejected.
// - upstream server lock does not gate commands here; only own selector.
// - test button press starts a 15 second internal bus connection test.
// - during the test the attached internal bus modules keep working normally.
// - auto rate detection on (default) or off with user link parameters.
// - auto detection tries every rate and parity pair until traffic matches.
// - frame: start, eight data, one stop with parity, one or two stops without.
// - detected rate and parity are held until power cycle (reset).
// - manual mode rate is 4800, 9600, 19200 or 38400 baud.
// - manual parity even, odd or none; none allows one or two stops.
// - slave address comes from two decimal rotary switches in both modes.
// - address and lock state are not writable by software.
// - valid addresses 1 to 99; 0 is broadcast; shipped setting 99.
// - traffic indicator steady at address 0, else lit during traffic only.
`ifndef SSAB_REGS_SVH
`define SSAB_REGS_SVH
`define SSAB_CTRL_OFS 12'h000
`define SSAB_STAT_OFS 12'h004
`define SSAB_RXDATA_OFS 12'h008
`define SSAB_TXDATA_OFS 12'h00C
`define SSAB_CTRL_RST 32'h0000_0001
`define SSAB_CTRL_AUTO_BIT 0
`define SSAB_CTRL_RATE_LSB 1
`define SSAB_CTRL_PAR_LSB 3
`define SSAB_CTRL_STOP2_BIT 5
`define SSAB_CLK_HZ 40000000
`define SSAB_TEST_S 15
`define SSAB_TEST_CYCLES (`SSAB_CLK_HZ * `SSAB_TEST_S)
`define SSAB_LOCK_FRAMES 4
`define SSAB_MAX_ADDR 7'd99
`define SSAB_FUNC_SET_TIME 8'h10
`define SSAB_FUNC_GET_TIME 8'h11
`endif

/* File: ssab_pkg.sv */
// types shared by the serial front end modules
package ssab_pkg;
  typedef enum logic [1:0] {SSAB_B4800, SSAB_B9600, SSAB_B19200, SSAB_B38400} ssab_rate_type;
  typedef enum logic [1:0] {SSAB_PAR_NONE, SSAB_PAR_EVEN, SSAB_PAR_ODD} ssab_par_type;
  typedef struct packed {
    ssab_rate_type rate;
    ssab_par_type par;
    logic stop2;
  } ssab_link_type;
  typedef struct packed {
    logic [7:0] data;
    logic ok;
  } ssab_rxchar_type;
endpackage : ssab_pkg

/* File: ssab_fifo.sv */
// flip-flop FIFO with valid and ready on both sides
module ssab_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem[rd_ptr];
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ssab_fifo

/* File: ssab_uart_rx.sv */
// serial character receiver with parity and stop checks
module ssab_uart_rx (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic rx_i,
  input wire logic [15:0] bit_cycles_i,
  input wire ssab_pkg::ssab_link_type link_i,
  output ssab_pkg::ssab_rxchar_type char_o,
  output logic done_o,
  output logic busy_o
);
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ssab_rx_state_type;
  ssab_rx_state_type state;
  logic [15:0] cnt;
  logic [3:0] idx;
  logic [7:0] sh;
  logic perr;
  assign busy_o = (state != ST_IDLE);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= ST_IDLE;
      cnt <= 16'h0000;
      idx <= 4'h0;
      sh <= 8'h00;
      perr <= 1'b0;
      done_o <= 1'b0;
      char_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (state != ST_IDLE && cnt != 16'h0000) begin
        cnt <= cnt - 16'h0001;
      end else begin
        unique case (state)
          ST_IDLE: if (!rx_i) begin
            state <= ST_START;
            cnt <= {1'b0, bit_cycles_i[15:1]};
          end
          ST_START: begin
            state <= rx_i ? ST_IDLE : ST_DATA;
            cnt <= bit_cycles_i;
            idx <= 4'h0;
            perr <= 1'b0;
          end
          ST_DATA: begin
            sh <= {rx_i, sh[7:1]};
            cnt <= bit_cycles_i;
            idx <= idx + 4'h1;
            if (idx == 4'h7) begin
              state <= (link_i.par == ssab_pkg::SSAB_PAR_NONE) ? ST_STOP : ST_PAR;
            end
          end
          ST_PAR: begin
            // even parity counts data plus parity bit to zero
            perr <= (^{sh, rx_i}) ^ (link_i.par == ssab_pkg::SSAB_PAR_ODD);
            cnt <= bit_cycles_i;
            state <= ST_STOP;
          end
          ST_STOP: begin
            // only the first stop bit is checked so two-stop senders also pass
            char_o.data <= sh;
            char_o.ok <= rx_i && !perr;
            done_o <= 1'b1;
            state <= ST_IDLE;
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule : ssab_uart_rx

/* File: ssab_master_model.sv */
// remote serial master model: sends characters and captures the block's replies
module ssab_master_model #(
  parameter int BIT_CYC = 1042
) (
  input wire logic clk_i,
  output logic line_o,
  input wire logic tx_i,
  input wire logic tx_en_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] got = 10'h000;
  // line is biased high between characters, so idle stays at one
  initial line_o = 1'b1;
  // even parity and one stop bit, data lsb first
  task automatic send(input logic [7:0] b);
    logic [10:0] fr;
    fr = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_o <= fr[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask : send
  // level wait avoids a race between enable rise and the start edge
  always begin
    wait (tx_en_i === 1'b1 && tx_i === 1'b0);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      got[i] = tx_i;
    end
    wait (tx_i === 1'b1);
  end
endmodule : ssab_master_model

/* File: ssab_front_end_tb.sv */
// self-checking bench of the serial front end with a remote master model
module ssab_front_end_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, rx, tx, tx_en, test_act, led, allowed;
  logic [3:0] tens = 4'h9;
  logic [3:0] units = 4'h9;
  logic lock = 1'b0;
  logic button = 1'b0;
  logic [31:0] rd;
  logic err;
  logic [7:0] b;
  int fails = 0;
  int n_compared = 0;
  always #12.5 clk = ~clk;
  ssab_front_end #(.TEST_CYCLES(1000), .LOCK_FRAMES(4)) uut (
    .CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .RX_I(rx), .TX_O(tx), .TX_EN_O(tx_en),
    .ADDR_TENS_I(tens), .ADDR_UNITS_I(units), .LOCK_CLOSED_I(lock),
    .TEST_BUTTON_I(button), .TEST_ACTIVE_O(test_act), .TRAFFIC_LED_O(led),
    .CMD_ALLOWED_O(allowed)
  );
  ssab_master_model #(.BIT_CYC(1042)) ptr (
    .clk_i(clk), .line_o(rx), .tx_i(tx), .tx_en_i(tx_en)
  );
  function automatic logic [31:0] exp_addr(input logic [3:0] t, input logic [3:0] u);
    return 32'(t) * 32'd10 + 32'(u);
  endfunction : exp_addr
  function automatic logic [31:0] ctrl_word(input logic [1:0] r, input logic [1:0] p,
                                            input logic s2);
    return {26'h0, s2, p, r, 1'b0};
  endfunction : ctrl_word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    int k;
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    if (k == lim) chk(32'h0, 32'h1);
  endtask : wait_lvl
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  initial begin
    #2000000;
    fails++;
    $display("BAD t=%0t watchdog expired", $time);
    test_done();
  end
  initial begin
    void'($urandom(32'hF2358442));
    cyc(2);
    rstn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 12'h004, 32'h0);
    chk({25'h0, rd[22:16]}, exp_addr(4'h9, 4'h9));
    chk({31'h0, rd[7]}, 32'h0);
    chk({31'h0, allowed}, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, err}, 32'h1);
    tens <= 4'($urandom_range(9, 1));
    units <= 4'($urandom_range(9));
    apb(1'b0, 12'h004, 32'h0);
    chk({25'h0, rd[22:16]}, exp_addr(tens, units));
    apb(1'b1, 12'h004, $urandom());
    apb(1'b0, 12'h004, 32'h0);
    chk({25'h0, rd[22:16]}, exp_addr(tens, units));
    tens <= 4'h0;
    units <= 4'h0;
    cyc(3);
    chk({31'h0, led}, 32'h1);
    tens <= 4'h9;
    units <= 4'h9;
    cyc(3);
    chk({31'h0, led}, 32'h0);
    lock <= 1'b1;
    cyc(3);
    chk({31'h0, allowed}, 32'h0);
    // every rate and parity code is written and read back before settling
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 12'h000, ctrl_word(2'(r), 2'(r % 3), r == 0));
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, ctrl_word(2'(r), 2'(r % 3), r == 0));
    end
    apb(1'b1, 12'h000, ctrl_word(2'd3, 2'd1, 1'b0));
    // under the lock a register read to slave 1 is refused, a set-time passes
    for (int f = 0; f < 2; f++) begin
      fork
        begin
          ptr.send((f == 0) ? 8'h01 : 8'h63);
          ptr.send((f == 0) ? 8'h03 : 8'h10);
        end
        begin
          cyc(3000);
          chk({31'h0, led}, 32'h1);
        end
      join
      cyc(100);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, (f == 0) ? 32'h0000_0001 : 32'h0000_0063);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, (f == 0) ? 32'h0000_0003 : 32'h0000_0010);
      cyc(1);
      chk({31'h0, allowed}, 32'(f));
      cyc(3);
    end
    b = 8'($urandom());
    apb(1'b1, 12'h00C, {24'h0, b});
    wait_lvl(tx_en, 1'b1, 100);
    wait_lvl(tx_en, 1'b0, 20000);
    chk({22'h0, ptr.got}, {22'h0, 1'b1, ^b, b});
    button <= 1'b1;
    cyc(5);
    chk({31'h0, test_act}, 32'h1);
    button <= 1'b0;
    cyc(500);
    button <= 1'b1;
    cyc(5);
    button <= 1'b0;
    cyc(390);
    chk({31'h0, test_act}, 32'h1);
    chk({31'h0, allowed}, 32'h1);
    cyc(120);
    chk({31'h0, test_act}, 32'h0);
    test_done();
  end
endmodule : ssab_front_end_tb
